// ---- inc/sto_pkg.sv ----
`default_nettype none
package sto_pkg;
    // clock and timing
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned SHUTOFF_MAX_US   = 1000;
    // longest time rounds down; sync stages plus decision must fit inside
    localparam int unsigned SHUTOFF_MAX_CYC  = (SHUTOFF_MAX_US * (CLK_HZ / 1_000_000));
    localparam int unsigned SYNC_STAGES      = 2;
    // digital output function code for software disable feedback
    localparam logic [7:0]  DOUT_FUNC_STO_FB = 8'h3A;
    // configuration reset values
    localparam logic        RESTART_PERM_RST = 1'b1;
    localparam logic        POST_BB_RST      = 1'b0;
    localparam logic [1:0]  STOP_METHOD_RST  = 2'h0;
    localparam logic [7:0]  DOUT_FUNC_RST    = 8'h00;
    // register map, word addresses
    localparam logic [3:0]  REG_CFG          = 4'h0;
    localparam logic [3:0]  REG_STATUS       = 4'h1;
    // field positions in REG_CFG
    localparam int unsigned CFG_RESTART_BIT  = 0;
    localparam int unsigned CFG_POSTBB_BIT   = 1;
    localparam int unsigned CFG_STOP_LSB     = 4;
    localparam int unsigned CFG_DOUT_LSB     = 8;
    // stop method codes
    localparam logic [1:0]  STOP_RAMP        = 2'h0;
    localparam logic [1:0]  STOP_COAST       = 2'h1;
    // operator display codes
    typedef enum logic [1:0] {
        STO_DISP_NORMAL   = 2'b00,
        STO_DISP_DISABLED = 2'b01,
        STO_DISP_MISMATCH = 2'b10
    } sto_disp_t;
    // drive state
    typedef enum logic [1:0] {
        STO_ST_TORQUE_OFF = 2'b00,
        STO_ST_BASEBLOCK  = 2'b01,
        STO_ST_RUN        = 2'b10
    } sto_state_t;
endpackage
`default_nettype wire

// ---- core/sto_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
// Operation
// - two independent disable channels block output
// - either channel open switches output off
// - torque off always coasts, ignores stop method
// - removing travel command gives baseblock only
// - leave torque off only with both closed
// - permission 0: held command must be cycled
// - permission 1: held command starts immediately
// - post-baseblock 0: reopen while held needs cycle
// - post-baseblock 1: restart when inputs reclose
// - hardware monitor off only when both off
// - function 58 output off only both on
// - both open flashes safely-disabled code
// - one channel open flashes mismatch code
// - both on: baseblock, ready, normal display
// - output off within one millisecond
module sto_ctrl (
    // clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    // disable channels, high = closed (enabled)
    input  wire logic             disable_in_a_i,
    input  wire logic             disable_in_b_i,
    // travel command, same clock domain
    input  wire logic             travel_cmd_i,
    // register port
    input  wire logic [3:0]       reg_addr_i,
    input  wire logic [31:0]      reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic      [31:0]      reg_rdata_o,
    // output stage and stop control
    output logic                  gate_enable_a_o,
    output logic                  gate_enable_b_o,
    output logic                  coast_stop_o,
    output logic                  ramp_stop_o,
    // monitors and display
    output logic                  hw_status_mon_o,
    output logic                  digital_out_o,
    output sto_pkg::sto_disp_t    display_code_o,
    output sto_pkg::sto_state_t   drive_state_o
);
    import sto_pkg::*;

    // refused at elaboration: sync stages plus the decision must beat the bound
    if (SYNC_STAGES + 2 > SHUTOFF_MAX_CYC) begin : g_latency_chk
        $error("shutoff latency cannot be met at this clock");
    end

    // synchronisers: stage 0 is read only by stage 1
    logic [1:0] sync0_q;
    logic [1:0] sync1_q;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync0_q <= 2'h0;
            sync1_q <= 2'h0;
        end else begin
            sync0_q <= {disable_in_b_i, disable_in_a_i};
            sync1_q <= sync0_q;
        end
    end

    // channel decode: each channel alone can block output
    wire ch_a_on     = sync1_q[0];
    wire ch_b_on     = sync1_q[1];
    wire both_on     = ch_a_on & ch_b_on;
    wire any_off     = ~both_on;
    wire both_off    = ~ch_a_on & ~ch_b_on;
    wire mismatch    = ch_a_on ^ ch_b_on;

    // configuration
    logic       restart_perm_q;
    logic       post_bb_q;
    logic [1:0] stop_method_q;
    logic [7:0] dout_func_q;
    wire cfg_wr = reg_wr_i & (reg_addr_i == REG_CFG);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            restart_perm_q <= RESTART_PERM_RST;
            post_bb_q      <= POST_BB_RST;
            stop_method_q  <= STOP_METHOD_RST;
            dout_func_q    <= DOUT_FUNC_RST;
        end else if (cfg_wr) begin
            restart_perm_q <= reg_wdata_i[CFG_RESTART_BIT];
            post_bb_q      <= reg_wdata_i[CFG_POSTBB_BIT];
            stop_method_q  <= reg_wdata_i[CFG_STOP_LSB +: 2];
            dout_func_q    <= reg_wdata_i[CFG_DOUT_LSB +: 8];
        end
    end

    // travel command edge tracking
    logic cmd_q;
    logic need_cycle_q;
    logic was_running_q;
    sto_state_t state_q;
    sto_state_t state_d;
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_q <= 1'b0;
        end else begin
            cmd_q <= travel_cmd_i;
        end
    end
    wire cmd_rise = travel_cmd_i & ~cmd_q;

    // a command held across torque off may need cycling before a start
    wire held_blocked = restart_perm_q ? (was_running_q ? ~post_bb_q : 1'b0) : 1'b1;
    wire leave_sto    = (state_q == STO_ST_TORQUE_OFF) & both_on;
    logic need_cycle_d;
    always_comb begin
        need_cycle_d = need_cycle_q;
        if (!travel_cmd_i) begin
            need_cycle_d = 1'b0;
        end else if (leave_sto) begin
            need_cycle_d = held_blocked & ~cmd_rise;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            need_cycle_q  <= 1'b0;
            was_running_q <= 1'b0;
        end else begin
            need_cycle_q <= need_cycle_d;
            if (state_q == STO_ST_RUN && any_off) begin
                was_running_q <= 1'b1;
            end else if (state_q == STO_ST_BASEBLOCK || !travel_cmd_i) begin
                was_running_q <= 1'b0;
            end
        end
    end

    wire may_run = both_on & travel_cmd_i & ~need_cycle_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            STO_ST_TORQUE_OFF: begin
                if (both_on) begin
                    state_d = may_run ? STO_ST_RUN : STO_ST_BASEBLOCK;
                end
            end
            STO_ST_BASEBLOCK: begin
                if (any_off) begin
                    state_d = STO_ST_TORQUE_OFF;
                end else if (may_run) begin
                    state_d = STO_ST_RUN;
                end
            end
            STO_ST_RUN: begin
                if (any_off) begin
                    state_d = STO_ST_TORQUE_OFF;
                end else if (!travel_cmd_i) begin
                    state_d = STO_ST_BASEBLOCK;
                end
            end
            default: state_d = STO_ST_TORQUE_OFF;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= STO_ST_TORQUE_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // outputs, all registered
    wire run_d      = (state_d == STO_ST_RUN);
    wire coast_d    = (state_q == STO_ST_RUN) & any_off;
    wire ramp_d     = (state_q == STO_ST_RUN) & both_on & ~travel_cmd_i
                      & (stop_method_q == STOP_RAMP);
    wire mon_d      = ~both_off;
    wire dout_d     = (dout_func_q == DOUT_FUNC_STO_FB) & ~both_on;
    sto_disp_t disp_d;
    assign disp_d   = both_off ? STO_DISP_DISABLED :
                      mismatch ? STO_DISP_MISMATCH :
                                 STO_DISP_NORMAL;

    wire [31:0] cfg_rd  = {16'h0000, dout_func_q, 2'h0, stop_method_q,
                           2'h0, post_bb_q, restart_perm_q};
    wire [31:0] stat_rd = {24'h0000_00, disp_d, state_q, mon_d, dout_d, ch_b_on, ch_a_on};
    wire [31:0] rd_d    = (reg_addr_i == REG_CFG)    ? cfg_rd  :
                          (reg_addr_i == REG_STATUS) ? stat_rd : 32'h0000_0000;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_enable_a_o <= 1'b0;
            gate_enable_b_o <= 1'b0;
            coast_stop_o    <= 1'b0;
            ramp_stop_o     <= 1'b0;
            hw_status_mon_o <= 1'b0;
            digital_out_o   <= 1'b0;
            display_code_o  <= STO_DISP_DISABLED;
            drive_state_o   <= STO_ST_TORQUE_OFF;
            reg_rdata_o     <= 32'h0000_0000;
        end else begin
            // each channel gates the stage on its own path
            gate_enable_a_o <= run_d & ch_a_on;
            gate_enable_b_o <= run_d & ch_b_on;
            coast_stop_o    <= coast_d;
            ramp_stop_o     <= ramp_d;
            hw_status_mon_o <= mon_d;
            digital_out_o   <= dout_d;
            display_code_o  <= disp_d;
            drive_state_o   <= state_d;
            reg_rdata_o     <= reg_rd_i ? rd_d : 32'h0000_0000;
        end
    end

    // assertions
    // sampled at the pins so the check also covers the two sync stages
    sequence chan_open_s;
        !(disable_in_a_i && disable_in_b_i);
    endsequence

    sequence stage_off_s;
        !gate_enable_a_o && !gate_enable_b_o;
    endsequence

    sequence held_reclose_s;
        leave_sto && travel_cmd_i && cmd_q && restart_perm_q;
    endsequence

    chan_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !ch_a_on |=> !gate_enable_a_o)
        else $error("channel a open but stage a enabled");

    chan_b_block_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !ch_b_on |=> !gate_enable_b_o)
        else $error("channel b open but stage b enabled");

    shutoff_time_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        chan_open_s |-> ##3 stage_off_s)
        else $error("output not off three cycles after open");

    sto_enter_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        any_off |=> drive_state_o == STO_ST_TORQUE_OFF)
        else $error("channel open without torque off");

    coast_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == STO_ST_RUN && any_off) |=> coast_stop_o && !ramp_stop_o)
        else $error("torque off without coast");

    cmd_baseblock_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == STO_ST_RUN && both_on && !travel_cmd_i) |=> state_q == STO_ST_BASEBLOCK)
        else $error("command removal did not give baseblock");

    sto_leave_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == STO_ST_TORQUE_OFF && any_off) |=> state_q == STO_ST_TORQUE_OFF)
        else $error("left torque off with a channel open");

    perm_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (leave_sto && !restart_perm_q && travel_cmd_i && cmd_q) |=> state_q != STO_ST_RUN)
        else $error("held command started with permission 0");

    perm_one_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (leave_sto && restart_perm_q && !was_running_q && travel_cmd_i) |=> state_q == STO_ST_RUN)
        else $error("held command did not start with permission 1");

    monitor_hw_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        both_off |=> !hw_status_mon_o)
        else $error("hardware monitor on with both off");

    mismatch_disp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        mismatch |=> display_code_o == STO_DISP_MISMATCH)
        else $error("mismatch code not shown");

    gate_run_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        drive_state_o != STO_ST_RUN |-> stage_off_s)
        else $error("stage enabled outside run");

    sto_only_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q != STO_ST_TORQUE_OFF && both_on) |=> state_q != STO_ST_TORQUE_OFF)
        else $error("torque off entered with both channels on");

    ramp_stop_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == STO_ST_RUN && both_on && !travel_cmd_i && stop_method_q == STOP_RAMP)
            |=> ramp_stop_o && !coast_stop_o)
        else $error("command removal did not ramp");

    ramp_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        ramp_stop_o |=> !ramp_stop_o)
        else $error("ramp stop longer than one cycle");

    coast_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        coast_stop_o |=> !coast_stop_o)
        else $error("coast stop longer than one cycle");

    sto_exit_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == STO_ST_TORQUE_OFF && both_on) |=> state_q != STO_ST_TORQUE_OFF)
        else $error("torque off kept with both channels closed");

    perm_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (state_q == STO_ST_BASEBLOCK && need_cycle_q && travel_cmd_i) |=> state_q != STO_ST_RUN)
        else $error("started before the command was cycled");

    post_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        held_reclose_s ##0 (!post_bb_q && was_running_q) |=> state_q != STO_ST_RUN)
        else $error("restarted on reclose with post-baseblock 0");

    post_one_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        held_reclose_s ##0 post_bb_q |=> state_q == STO_ST_RUN)
        else $error("no restart on reclose with post-baseblock 1");

    monitor_on_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !both_off |=> hw_status_mon_o)
        else $error("hardware monitor off with a channel on");

    dout_on_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (dout_func_q == DOUT_FUNC_STO_FB && !both_on) |=> digital_out_o)
        else $error("software feedback off with a channel open");

    dout_off_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (dout_func_q != DOUT_FUNC_STO_FB || both_on) |=> !digital_out_o)
        else $error("software feedback on when it should be off");

    disabled_disp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        both_off |=> display_code_o == STO_DISP_DISABLED)
        else $error("safely disabled code not shown");

    normal_disp_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        both_on |=> display_code_o == STO_DISP_NORMAL && drive_state_o != STO_ST_TORQUE_OFF)
        else $error("both channels on without normal display");

    sync_a_open_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !disable_in_a_i |-> ##2 !ch_a_on)
        else $error("channel a open not seen after two stages");

    sync_b_open_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !disable_in_b_i |-> ##2 !ch_b_on)
        else $error("channel b open not seen after two stages");

    sync_a_close_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        disable_in_a_i |-> ##2 ch_a_on)
        else $error("channel a close not seen after two stages");

    sync_b_close_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        disable_in_b_i |-> ##2 ch_b_on)
        else $error("channel b close not seen after two stages");
endmodule
`default_nettype wire

// ---- tb/sto_relay_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sto_relay_model #(
    parameter int unsigned HOLD_CYC = 8
) (
    // clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // bench requests, high = open that channel
    input  wire logic open_a_i,
    input  wire logic open_b_i,
    // feedback from the drive
    input  wire logic hw_status_mon_i,
    // disable channels, high = closed
    output logic      disable_in_a_o,
    output logic      disable_in_b_o
);
    logic [15:0] hold_q;
    logic        mon_off_q;
    wire         both_open = !disable_in_a_o && !disable_in_b_o;
    wire         any_open  = !disable_in_a_o || !disable_in_b_o;
    // with both open, a monitor that never dropped means a broken circuit: stay open
    wire         may_close = (hold_q >= HOLD_CYC) && (mon_off_q || !both_open);
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_q         <= 16'h0000;
            mon_off_q      <= 1'h0;
            disable_in_a_o <= 1'h0;
            disable_in_b_o <= 1'h0;
        end else begin
            hold_q         <= !any_open ? 16'h0000 : (hold_q + {15'h0000, hold_q < HOLD_CYC});
            mon_off_q      <= any_open && (mon_off_q || (both_open && !hw_status_mon_i));
            disable_in_a_o <= !open_a_i && (disable_in_a_o || may_close);
            disable_in_b_o <= !open_b_i && (disable_in_b_o || may_close);
        end
    end
endmodule
`default_nettype wire

// ---- tb/sto_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module sto_ctrl_tb;
    import sto_pkg::*;
    localparam int unsigned HOLD = 8;
    logic        core_clk_i;
    logic        rst_n_i      = 1'h0;
    logic        travel_cmd_i = 1'h0;
    logic        reg_wr_i     = 1'h0;
    logic        reg_rd_i     = 1'h0;
    logic [3:0]  reg_addr_i   = 4'h0;
    logic [31:0] reg_wdata_i  = 32'h0000_0000;
    logic        open_a       = 1'h1;
    logic        open_b       = 1'h1;
    logic        dis_a, dis_b, gate_a, gate_b, coast, ramp, mon, dout;
    logic [31:0] reg_rdata_o, d;
    sto_disp_t   disp;
    sto_state_t  st;
    int          bad_count, check_count, cyc, coast_n, ramp_n, c0, r0;
    sto_ctrl DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .disable_in_a_i(dis_a),
        .disable_in_b_i(dis_b), .travel_cmd_i(travel_cmd_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .gate_enable_a_o(gate_a), .gate_enable_b_o(gate_b),
        .coast_stop_o(coast), .ramp_stop_o(ramp), .hw_status_mon_o(mon),
        .digital_out_o(dout), .display_code_o(disp), .drive_state_o(st));
    sto_relay_model #(.HOLD_CYC(HOLD)) u_relay (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .open_a_i(open_a), .open_b_i(open_b), .hw_status_mon_i(mon),
        .disable_in_a_o(dis_a), .disable_in_b_o(dis_b));
    initial begin
        core_clk_i = 1'h0;
        forever #25 core_clk_i = ~core_clk_i;
    end
    // stop pulses last one cycle, so they are counted as they pass
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (coast === 1'h1) coast_n <= coast_n + 1;
        if (ramp === 1'h1) ramp_n <= ramp_n + 1;
        if (cyc == 3000) begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= v;
        reg_wr_i    <= 1'h1;
        @(posedge core_clk_i);
        reg_wr_i    <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'h1;
        @(posedge core_clk_i);
        reg_rd_i   <= 1'h0;
        #1 d = reg_rdata_o;
    endtask
    task automatic chan(input logic a, input logic b);
        @(posedge core_clk_i);
        open_a <= a;
        open_b <= b;
        tick(HOLD + 6);
    endtask
    task automatic cmd(input logic v);
        @(posedge core_clk_i);
        travel_cmd_i <= v;
        tick(3);
    endtask
    task automatic outs(input sto_state_t s, input sto_disp_t p, input logic m, input logic o);
        chk("state", 32'(s), 32'(st));
        chk("display", 32'(p), 32'(disp));
        chk("hw_mon", 32'(m), 32'(mon));
        chk("dig_out", 32'(o), 32'(dout));
        chk("gate_a", 32'(s == STO_ST_RUN), 32'(gate_a));
        chk("gate_b", 32'(s == STO_ST_RUN), 32'(gate_b));
    endtask
    task automatic t_regs();
        rd(REG_CFG);
        chk("cfg_reset", 32'h0000_0001, d);
        wr(REG_CFG, 32'h0000_3A01);
        wr(REG_STATUS, 32'hFFFF_FFFF);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF);
        chk("unmapped", 32'h0000_0000, d);
        rd(REG_CFG);
        chk("cfg", 32'h0000_3A01, d);
        rd(REG_STATUS);
        chk("status", 32'h0000_0044, d);
        outs(STO_ST_TORQUE_OFF, STO_DISP_DISABLED, 1'h0, 1'h1);
        $display("done registers");
    endtask
    task automatic t_mismatch();
        chan(1'h0, 1'h0);
        outs(STO_ST_BASEBLOCK, STO_DISP_NORMAL, 1'h1, 1'h0);
        cmd(1'h1);
        outs(STO_ST_RUN, STO_DISP_NORMAL, 1'h1, 1'h0);
        c0 = coast_n;
        r0 = ramp_n;
        chan(1'h1, 1'h0);
        outs(STO_ST_TORQUE_OFF, STO_DISP_MISMATCH, 1'h1, 1'h1);
        chk("coast", 32'(c0 + 1), 32'(coast_n));
        chk("ramp", 32'(r0), 32'(ramp_n));
        rd(REG_STATUS);
        chk("status", 32'h0000_008E, d);
        chan(1'h0, 1'h1);
        outs(STO_ST_TORQUE_OFF, STO_DISP_MISMATCH, 1'h1, 1'h1);
        chan(1'h0, 1'h0);
        outs(STO_ST_BASEBLOCK, STO_DISP_NORMAL, 1'h1, 1'h0);
        cmd(1'h0);
        cmd(1'h1);
        outs(STO_ST_RUN, STO_DISP_NORMAL, 1'h1, 1'h0);
        r0 = ramp_n;
        cmd(1'h0);
        outs(STO_ST_BASEBLOCK, STO_DISP_NORMAL, 1'h1, 1'h0);
        chk("ramp", 32'(r0 + 1), 32'(ramp_n));
        $display("done mismatch");
    endtask
    task automatic t_restart();
        wr(REG_CFG, 32'h0000_3A00);
        chan(1'h1, 1'h1);
        cmd(1'h1);
        outs(STO_ST_TORQUE_OFF, STO_DISP_DISABLED, 1'h0, 1'h1);
        chan(1'h0, 1'h0);
        outs(STO_ST_BASEBLOCK, STO_DISP_NORMAL, 1'h1, 1'h0);
        cmd(1'h0);
        cmd(1'h1);
        outs(STO_ST_RUN, STO_DISP_NORMAL, 1'h1, 1'h0);
        wr(REG_CFG, 32'h0000_3A01);
        cmd(1'h0);
        chan(1'h1, 1'h1);
        cmd(1'h1);
        chan(1'h0, 1'h0);
        outs(STO_ST_RUN, STO_DISP_NORMAL, 1'h1, 1'h0);
        wr(REG_CFG, 32'h0000_3A03);
        chan(1'h1, 1'h1);
        outs(STO_ST_TORQUE_OFF, STO_DISP_DISABLED, 1'h0, 1'h1);
        chan(1'h0, 1'h0);
        outs(STO_ST_RUN, STO_DISP_NORMAL, 1'h1, 1'h0);
        rd(REG_STATUS);
        chk("status", 32'h0000_002B, d);
        wr(REG_CFG, 32'h0000_3A13);
        rd(REG_CFG);
        chk("cfg_coast", 32'h0000_3A13, d);
        r0 = ramp_n;
        c0 = coast_n;
        cmd(1'h0);
        outs(STO_ST_BASEBLOCK, STO_DISP_NORMAL, 1'h1, 1'h0);
        chk("ramp", 32'(r0), 32'(ramp_n));
        chk("coast", 32'(c0), 32'(coast_n));
        $display("done restart");
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'h1;
        tick(4);
        t_regs();
        t_mismatch();
        t_restart();
        summarize();
    end
endmodule
`default_nettype wire
